// [logic/output_node_defines.vh]
`ifndef OUTPUT_NODE_DEFINES_VH
`define OUTPUT_NODE_DEFINES_VH
// Clock rate in kHz
`define CLK_KHZ 125000
// Highest node address that is accepted
`define ADDR_MAX 6'h3d
// Output bits occupied on the bus
`define NODE_CHANNELS 8
// Blanking pulse before each retry, in ns, and its cycle count
`define BLANK_NS 20000
`define BLANK_CYC ((`BLANK_NS * (`CLK_KHZ / 1000)) / 1000)
// Switch-off delay after a short, in ns, and its cycle count (rounded down)
`define TRIP_NS 150000
`define TRIP_CYC ((`TRIP_NS * (`CLK_KHZ / 1000)) / 1000)
// Error report hold, in ms, and its cycle count
`define HOLD_MS 5000
`define HOLD_CYC (`HOLD_MS * `CLK_KHZ)
// Retry interval, in ms, and its cycle count
`define RETRY_MS 20
`define RETRY_CYC (`RETRY_MS * `CLK_KHZ)
// Initialization phase, in ms, and its cycle count
`define INIT_MS 100
`define INIT_CYC (`INIT_MS * `CLK_KHZ)
// Error code sent on overload and the channel it names
`define ERR_CODE_OVL 4'h4
`define ERR_CHAN_OVL 3'h0
`endif

// [logic/remote_binary_output_node.v]
`timescale 1ns/1ns
`default_nettype none
`include "output_node_defines.vh"
// Contract
// - Node address from switches must be within 0 to 61.
// - Switch eight selects bus bit positions 00-07 or 08-15.
// - Node takes exactly eight output bit positions on the bus.
// - During initialization bus error, overload and supply indicators are lit.
// - After initialization red indicators go out if bus fine and no fault.
// - One indicator per channel shows its commanded state.
// - Overheated channel is switched off, then retried periodically.
// - Before each retry all channels are forced off for about 20 us.
// - Cleared fault resumes channel at once; overload indicator goes out. Code waits for the next retry blanking to end.
// - Overload sends error report with code four.
// - Error report always names channel zero.
// - Error report is held at least five seconds.
// - Overload indicator lit on any fault, bus running or not.
// - Bus error indicator lit whenever bus communication is not running.
// - Shorted output is switched off within about 150 us.
module remote_binary_output_node #(
  parameter integer HOLD_CYC = `HOLD_CYC,
  parameter integer RETRY_CYC = `RETRY_CYC,
  parameter integer INIT_CYC = `INIT_CYC
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Address switches (pins)
  input wire [5:0] addr_sw,
  input wire half_sel_sw,
  // Bus side, same clock domain
  input wire bus_running,
  input wire out_word_valid,
  input wire [15:0] out_word,
  // Over-temperature sense per channel (pins)
  input wire [7:0] overheat_pin,
  // Output drivers and indicators
  output reg [7:0] out_drive,
  output reg [7:0] led_chan,
  output reg led_bus_err,
  output reg led_overload,
  output reg led_supply,
  // Error report to master
  output reg err_report,
  output reg [3:0] err_code,
  output reg [2:0] err_chan,
  output reg addr_valid
);

  // Short fixed timings; the long ones are parameters so a bench can
  // shrink them without touching the blanking or trip behaviour
  localparam [31:0] BLANK_CYC = `BLANK_CYC;
  localparam [31:0] TRIP_CYC = `TRIP_CYC;

  // Nonzero test for the 32-bit timers, asked in two places
  function busy32(input [31:0] cnt);
    busy32 = (cnt != 32'h0);
  endfunction

  // Two-flop synchronisers for pins
  // Only the second stage feeds logic; the first may still be settling
  reg [7:0] ovh_s1_q, ovh_q;
  reg [5:0] addr_s1_q, addr_q;
  reg half_s1_q, half_q;
  always @(posedge clk_sys) begin
    ovh_s1_q <= overheat_pin;
    ovh_q <= ovh_s1_q;
    addr_s1_q <= addr_sw;
    addr_q <= addr_s1_q;
    half_s1_q <= half_sel_sw;
    half_q <= half_s1_q;
  end

  // Init counter; status indicators all lit meanwhile
  // Words arriving before it ends are dropped, the node is not ready yet
  reg [31:0] init_cnt_q;
  wire init_done = (init_cnt_q >= INIT_CYC);
  always @(posedge clk_sys) begin
    if (rst) begin
      init_cnt_q <= 32'h0;
    end else if (!init_done) begin
      init_cnt_q <= init_cnt_q + 32'h1;
    end
  end

  // Command latch: pick our half of the word, fixed map, no config
  // The other half of the word belongs to a neighbouring node and is ignored
  reg [7:0] cmd_q;
  always @(posedge clk_sys) begin
    if (rst) begin
      cmd_q <= 8'h00;
    end else if (out_word_valid && addr_valid && init_done) begin
      cmd_q <= half_q ? out_word[15:8] : out_word[7:0];
    end
  end

  // Per-channel trip: overheat for TRIP_CYC cycles latches channel off
  reg [7:0] trip_q;
  wire [7:0] trip_set;
  // A hot spell shorter than the trip time is ridden out with the channel on
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_trip
      reg [31:0] hot_cnt_q;
      assign trip_set[g] = ovh_q[g] && (hot_cnt_q + 32'h1 >= TRIP_CYC);
      always @(posedge clk_sys) begin
        if (rst || !ovh_q[g] || trip_q[g]) begin
          hot_cnt_q <= 32'h0;
        end else begin
          hot_cnt_q <= hot_cnt_q + 32'h1;
        end
      end
    end
  endgenerate

  // Retry timer and global blanking pulse
  // The timer only runs while a channel is tripped, so a healthy node never blanks
  reg [31:0] retry_cnt_q;
  reg [31:0] blank_cnt_q;
  wire blanking = busy32(blank_cnt_q);
  wire retry_fire = (trip_q != 8'h00) && (retry_cnt_q + 32'h1 >= RETRY_CYC) && !blanking;
  wire blank_end = (blank_cnt_q == 32'h1);
  always @(posedge clk_sys) begin
    if (rst) begin
      retry_cnt_q <= 32'h0;
      blank_cnt_q <= 32'h0;
    end else begin
      if (trip_q == 8'h00 || retry_fire || blanking) begin
        retry_cnt_q <= 32'h0;
      end else begin
        retry_cnt_q <= retry_cnt_q + 32'h1;
      end
      if (retry_fire) begin
        blank_cnt_q <= BLANK_CYC;
      end else if (blanking) begin
        blank_cnt_q <= blank_cnt_q - 32'h1;
      end
    end
  end

  // Trip state; at end of blanking tripped channels are re-enabled
  always @(posedge clk_sys) begin
    if (rst) begin
      trip_q <= 8'h00;
    end else begin
      // New trip wins over a re-enable in the same cycle
      trip_q <= (blank_end ? 8'h00 : trip_q) | trip_set;
    end
  end

  wire fault_any = (trip_q != 8'h00);

  // Error report hold, at least HOLD_CYC after the fault last seen
  // Reloaded every cycle a trip stands, so a quick clear still gets the full hold
  reg [31:0] hold_cnt_q;
  always @(posedge clk_sys) begin
    if (rst) begin
      hold_cnt_q <= 32'h0;
    end else if (fault_any) begin
      hold_cnt_q <= HOLD_CYC;
    end else if (hold_cnt_q != 32'h0) begin
      hold_cnt_q <= hold_cnt_q - 32'h1;
    end
  end

  // Report stands while a trip stands or the hold timer still runs
  wire report_active = fault_any || busy32(hold_cnt_q);

  // Address check; an out-of-range setting leaves the node deaf
  always @(posedge clk_sys) begin
    if (rst) begin
      addr_valid <= 1'b0;
    end else begin
      addr_valid <= (addr_q <= `ADDR_MAX);
    end
  end

  // Channel drives and their indicators; blanking hits every channel
  // and tripped ones stay off, the indicators keep showing the command
  always @(posedge clk_sys) begin
    if (rst) begin
      out_drive <= 8'h00;
      led_chan <= 8'h00;
    end else begin
      out_drive <= blanking ? 8'h00 : (cmd_q & ~trip_q);
      led_chan <= cmd_q;
    end
  end

  // Status indicators; all lit until initialization ends
  // Supply lamp is always lit here since the logic only runs when powered
  always @(posedge clk_sys) begin
    if (rst) begin
      led_bus_err <= 1'b1;
      led_overload <= 1'b1;
      led_supply <= 1'b1;
    end else begin
      led_supply <= 1'b1;
      if (!init_done) begin
        led_bus_err <= 1'b1;
        led_overload <= 1'b1;
      end else begin
        // Overload lamp does not care whether the bus runs
        led_bus_err <= !bus_running;
        led_overload <= fault_any;
      end
    end
  end

  // Error report to the master; code and channel are fixed, the hold
  // keeps a brief short visible long enough for the master to see it
  always @(posedge clk_sys) begin
    if (rst) begin
      err_report <= 1'b0;
      err_code <= 4'h0;
      err_chan <= 3'h0;
    end else begin
      err_report <= report_active;
      err_code <= report_active ? `ERR_CODE_OVL : 4'h0;
      err_chan <= `ERR_CHAN_OVL;
    end
  end

endmodule // remote_binary_output_node
`default_nettype wire

// [tb/central_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Bus master; the arrangement is fixed so no setup frames are sent
module central_master_model (
  // Clock
  input wire logic clk_sys,
  // Node bus side
  output var logic bus_running = 1'b0,
  output var logic out_word_valid = 1'b0,
  output var logic [15:0] out_word = 16'h0000
);
  // One strobed word; data is scrambled after the strobe drops
  task send(input logic [15:0] w);
    @(posedge clk_sys) out_word_valid <= 1'b1;
    out_word <= w;
    @(posedge clk_sys) out_word_valid <= 1'b0;
    out_word <= ~w;
  endtask
  task set_bus(input logic b);
    @(posedge clk_sys) bus_running <= b;
  endtask
endmodule // central_master_model
`default_nettype wire

// [tb/output_node_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module output_node_asserts #(parameter integer HOLD_CYC = 200) (
  // Watched ports
  input wire logic clk_sys, rst, bus_running, led_bus_err, led_overload, led_supply,
  input wire logic err_report,
  input wire logic [7:0] out_drive, led_chan,
  input wire logic [3:0] err_code,
  input wire logic [2:0] err_chan
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  integer hcnt;
  // Age of the report, so a short fault cannot cut it
  always @(posedge clk_sys) hcnt <= err_report ? hcnt + 1 : 0;
  sequence bus_dead;
    !bus_running [*4];
  endsequence
  // Power-on picture: every status lamp stays lit for a while after reset
  sequence init_lit;
    (led_bus_err && led_overload && led_supply) [*8];
  endsequence
  chk_supply_lit: assert property (led_supply) else $error("supply dark");
  chk_chan_zero: assert property (err_chan == 3'h0) else $error("chan");
  chk_code_four: assert property (err_report |-> err_code == 4'h4) else $error("code");
  chk_code_idle: assert property (!err_report |-> err_code == 4'h0)
    else $error("idle code");
  chk_init_lit: assert property ($fell(rst) |-> init_lit)
    else $error("init leds");
  chk_bus_dead: assert property (bus_dead |-> led_bus_err) else $error("bus led");
  chk_ovl_report: assert property ($rose(led_overload) && !$past(rst) |-> ##[0:2] err_report)
    else $error("no report");
  chk_drive_cmd: assert property ((out_drive & ~led_chan) == 8'h00) else $error("drive");
  chk_hold_min: assert property ($fell(err_report) |-> hcnt >= HOLD_CYC)
    else $error("hold");
endmodule // output_node_asserts
`default_nettype wire

// [tb/remote_binary_output_node_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module remote_binary_output_node_tb_top;
  logic clk_sys, rst, half_sel_sw, bus_running, out_word_valid, led_bus_err, led_overload;
  logic led_supply, err_report, addr_valid;
  logic [5:0] addr_sw;
  logic [7:0] overheat_pin, out_drive, led_chan;
  logic [15:0] out_word;
  logic [3:0] err_code;
  logic [2:0] err_chan;
  integer miscompares = 0, comparisons = 0, cycles = 0, i;
  central_master_model m (.clk_sys(clk_sys), .bus_running(bus_running),
    .out_word_valid(out_word_valid), .out_word(out_word));
  remote_binary_output_node #(.HOLD_CYC(4000), .RETRY_CYC(3000), .INIT_CYC(20)) dut (
    .clk_sys(clk_sys), .rst(rst), .addr_sw(addr_sw), .half_sel_sw(half_sel_sw),
    .bus_running(bus_running), .out_word_valid(out_word_valid), .out_word(out_word),
    .overheat_pin(overheat_pin), .out_drive(out_drive), .led_chan(led_chan),
    .led_bus_err(led_bus_err), .led_overload(led_overload), .led_supply(led_supply),
    .err_report(err_report), .err_code(err_code), .err_chan(err_chan), .addr_valid(addr_valid));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Ceiling: trip, retry, blank and hold take about 28k cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      tally_and_finish;
    end
  end
  // Tests
  initial begin
    rst = 1'b1; addr_sw = 6'h05; half_sel_sw = 1'b0; overheat_pin = 8'h00;
    tick(10);
    chk({led_bus_err, led_overload, led_supply}, 3'h7);
    rst <= 1'b0;
    tick(30);
    chk(led_bus_err, 1'b1);
    m.set_bus(1'b1);
    tick(5);
    chk({led_bus_err, led_overload, led_supply}, 3'h1);
    $display("init done");
    m.send(16'h5aa5);
    tick(3);
    chk({led_chan, out_drive}, 16'ha5a5);
    half_sel_sw <= 1'b1;
    tick(4);
    m.send(16'h5aa5);
    tick(3);
    chk(led_chan, 8'h5a);
    addr_sw <= 6'h3e;
    tick(4);
    m.send(16'hff00);
    tick(3);
    chk({addr_valid, led_chan}, 9'h05a);
    addr_sw <= 6'h3d;
    tick(4);
    m.send(16'h0f00);
    tick(3);
    chk(led_chan, 8'h0f);
    $display("mapping done");
    overheat_pin <= 8'h01;
    tick(18760);
    chk(out_drive, 8'h0e);
    chk({led_overload, err_report, err_code, err_chan}, 9'h1a0);
    m.set_bus(1'b0);
    tick(5);
    chk({led_bus_err, led_overload}, 2'h3);
    m.set_bus(1'b1);
    for (i = 0; i < 3100 && out_drive !== 8'h00; i = i + 1) tick(1);
    chk(i > 2900 && i < 3100, 1'b1);
    overheat_pin <= 8'h00;
    tick(2000);
    chk(out_drive, 8'h00);
    tick(600);
    chk({led_overload, err_report, out_drive}, 10'h10f);
    tick(4010);
    chk({err_report, err_code}, 5'h00);
    $display("fault done");
    // Brief heat on the other channels must not trip anything
    overheat_pin <= 8'hfe;
    tick(100);
    chk({led_overload, out_drive}, 9'h00f);
    overheat_pin <= 8'h00;
    // Second reset in mid-run restarts the initialization picture
    rst <= 1'b1;
    tick(3);
    chk({led_bus_err, led_overload, led_supply, err_report}, 4'he);
    rst <= 1'b0;
    tick(10);
    chk({led_bus_err, led_overload, led_supply}, 3'h7);
    m.send(16'hff00);
    tick(15);
    chk({led_bus_err, led_overload, led_supply, led_chan}, 11'h100);
    $display("reset done");
    tally_and_finish;
  end
endmodule // remote_binary_output_node_tb_top
bind remote_binary_output_node output_node_asserts #(.HOLD_CYC(HOLD_CYC)) chk (
  .clk_sys(clk_sys), .rst(rst), .bus_running(bus_running), .led_bus_err(led_bus_err),
  .led_overload(led_overload), .led_supply(led_supply), .err_report(err_report),
  .out_drive(out_drive), .led_chan(led_chan), .err_code(err_code), .err_chan(err_chan));
`default_nettype wire
